/* File: src/esb_bridge.sv */
// System-bus bridge to an 8 or 16 bit external static memory bus
`timescale 1ns/100ps
`default_nettype none
module esb_bridge #(
  parameter int unsigned addr_bits_param = esb_pkg::ADDR_BITS_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [addr_bits_param-1:0] ext_addr,
  output logic [15:0] ext_write_data,
  input wire logic [15:0] ext_read_data,
  output logic data_drive_enable_n,
  output logic mem_write_strobe_n,
  output logic mem_read_enable_n,
  output logic mem_select_n,
  output logic low_lane_enable_n,
  output logic high_lane_enable_n
);
  localparam int unsigned AW = addr_bits_param;
  localparam int unsigned REQ_W = AW + 3 + 32;

  typedef struct packed {
    logic [esb_pkg::CFG_W-1:0] cfg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [AW-1:0] a_addr;
    logic [1:0] a_size;
    logic a_write;
    logic dphase;
    logic pushed;
    logic hready_o;
    logic hresp;
    logic [31:0] hrdata;
    esb_pkg::esb_state_t st;
    logic [AW-1:0] j_addr;
    logic [1:0] j_size;
    logic j_write;
    logic [31:0] j_wdata;
    logic [31:0] j_rdata;
    logic [1:0] beats_left;
    logic last_wr;
    logic dir_known;
    logic [2:0] run;
    logic [AW-1:0] ea;
    logic [15:0] ewd;
    logic doe_n;
    logic we_n;
    logic oe_n;
    logic ce_n;
    logic lb_n;
    logic ub_n;
  } esb_top_state_t;

  esb_top_state_t q;
  esb_top_state_t d;

  logic [2:0] rd_set;
  logic [2:0] wr_set;
  logic [2:0] ta_set;
  logic wide;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [REQ_W-1:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [REQ_W-1:0] buf_out_data;
  logic cnt_load;
  logic [2:0] cnt_val;
  logic cnt_last;
  logic start_beat;
  logic start_wr;
  logic beat_end;
  logic [1:0] lane;
  logic [1:0] stride;
  logic active;

  //////////////////////////////////////////////////////////////////////////
  // Lane and beat decoding

  // Beats minus one for one system transfer
  function automatic logic [1:0] beat_count(input logic [1:0] size,
                                            input logic wd);
    logic [1:0] r;
    r = 2'h0;
    if (!wd) begin
      case (size)
        esb_pkg::SIZE_HALF: r = 2'h1;
        esb_pkg::SIZE_WORD: r = 2'h3;
        default: r = 2'h0;
      endcase
    end else if (size == esb_pkg::SIZE_WORD) begin
      r = 2'h1;
    end
    return r;
  endfunction

  // Lowest system byte lane carried by the current beat
  function automatic logic [1:0] lane_of(input logic [1:0] a,
                                         input logic wd);
    return wd ? {a[1], 1'b0} : a;
  endfunction

  assign rd_set = q.cfg[esb_pkg::CFG_RD_LSB +: 3];
  assign wr_set = q.cfg[esb_pkg::CFG_WR_LSB +: 3];
  assign ta_set = q.cfg[esb_pkg::CFG_TA_LSB +: 3];
  assign wide = q.cfg[esb_pkg::CFG_WIDE_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Request buffer and phase timer

  // Request is pushed in the data phase, once write data is valid
  assign buf_in_valid = q.dphase && !q.pushed;
  assign buf_in_data = {q.a_addr, q.a_size, q.a_write, hwdata};

  esb_buf2 #(.W(REQ_W)) u_req_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  esb_wait_cnt u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .load(cnt_load),
    .load_val(cnt_val),
    .last(cnt_last)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    d = q;
    buf_out_ready = 1'b0;
    cnt_load = 1'b0;
    cnt_val = 3'h0;
    start_beat = 1'b0;
    start_wr = 1'b0;
    beat_end = 1'b0;
    lane = 2'h0;
    stride = 2'h1;
    active = 1'b0;
    d.hresp = esb_pkg::HRESP_OKAY;

    // Register slave: answers in the first access cycle
    d.pready = 1'b0;
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      case (paddr)
        esb_pkg::CFG_OFFSET: d.prdata = {22'h0, q.cfg};
        esb_pkg::STATUS_OFFSET: begin
          d.prdata = esb_pkg::UNMAPPED_DATA;
          d.prdata[esb_pkg::ST_BUSY_BIT] = (q.st != esb_pkg::ST_IDLE)
                                           || q.dphase;
          d.prdata[esb_pkg::ST_LASTWR_BIT] = q.last_wr;
          d.prdata[esb_pkg::ST_QUEUED_BIT] = buf_out_valid;
        end
        default: begin
          d.prdata = esb_pkg::UNMAPPED_DATA;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && q.pready && pwrite
        && paddr == esb_pkg::CFG_OFFSET) begin
      d.cfg = pwdata[esb_pkg::CFG_W-1:0];
    end

    if (buf_in_valid && buf_in_ready) begin
      d.pushed = 1'b1;
    end

    // External engine
    case (q.st)
      esb_pkg::ST_IDLE: begin
        if (buf_out_valid) begin
          buf_out_ready = 1'b1;
          {d.j_addr, d.j_size, d.j_write, d.j_wdata} = buf_out_data;
          d.j_rdata = 32'h0000_0000;
          d.beats_left = beat_count(d.j_size, wide);
          if (q.dir_known && q.last_wr != d.j_write) begin
            d.st = esb_pkg::ST_TURN;
            cnt_load = 1'b1;
            cnt_val = ta_set;
          end else begin
            start_beat = 1'b1;
            start_wr = d.j_write;
          end
        end
      end
      esb_pkg::ST_TURN: begin
        if (cnt_last) begin
          start_beat = 1'b1;
          start_wr = q.j_write;
        end
      end
      esb_pkg::ST_SETUP: begin
        d.st = esb_pkg::ST_WRITE;
        cnt_load = 1'b1;
        cnt_val = wr_set;
      end
      esb_pkg::ST_WRITE: begin
        if (cnt_last) begin
          d.st = esb_pkg::ST_HOLD;
        end
      end
      esb_pkg::ST_HOLD: begin
        beat_end = 1'b1;
      end
      esb_pkg::ST_READ: begin
        if (cnt_last) begin
          lane = lane_of(q.j_addr[1:0], wide);
          if (wide) begin
            d.j_rdata[{lane, 3'b000} +: 16] = ext_read_data;
          end else begin
            d.j_rdata[{lane, 3'b000} +: 8] = ext_read_data[7:0];
          end
          beat_end = 1'b1;
        end
      end
      default: d.st = esb_pkg::ST_IDLE;
    endcase

    // Split wide accesses into consecutive beats
    if (beat_end) begin
      if (q.beats_left != 2'h0) begin
        if (wide && q.j_size != esb_pkg::SIZE_BYTE) begin
          stride = 2'h2;
        end
        d.beats_left = q.beats_left - 2'h1;
        d.j_addr = q.j_addr + {{(AW-2){1'b0}}, stride};
        start_beat = 1'b1;
        start_wr = q.j_write;
      end else begin
        d.st = esb_pkg::ST_IDLE;
        d.hready_o = 1'b1;
        d.hrdata = d.j_rdata;
        d.dphase = 1'b0;
        d.last_wr = q.j_write;
        d.dir_known = 1'b1;
      end
    end

    if (start_beat) begin
      if (start_wr) begin
        d.st = esb_pkg::ST_SETUP;
      end else begin
        d.st = esb_pkg::ST_READ;
        cnt_load = 1'b1;
        cnt_val = rd_set;
      end
    end

    // Address phase; our own pending transfer keeps hready low meanwhile
    if (hsel && htrans[esb_pkg::HTRANS_ACTIVE_BIT] && hready) begin
      d.a_addr = haddr[AW-1:0];
      d.a_size = hsize[1:0];
      d.a_write = hwrite;
      d.dphase = 1'b1;
      d.pushed = 1'b0;
      d.hready_o = 1'b0;
    end

    // Pins follow the next state so they leave the flops in step with it
    active = (d.st == esb_pkg::ST_SETUP) || (d.st == esb_pkg::ST_WRITE)
             || (d.st == esb_pkg::ST_HOLD) || (d.st == esb_pkg::ST_READ);
    d.ce_n = !active;
    d.oe_n = (d.st != esb_pkg::ST_READ);
    d.we_n = (d.st != esb_pkg::ST_WRITE);
    d.doe_n = !((d.st == esb_pkg::ST_SETUP) || (d.st == esb_pkg::ST_WRITE)
                || (d.st == esb_pkg::ST_HOLD));
    d.ea = d.j_addr;
    lane = lane_of(d.j_addr[1:0], wide);
    if (wide) begin
      d.ewd = d.j_wdata[{lane, 3'b000} +: 16];
    end else begin
      d.ewd = {8'h00, d.j_wdata[{lane, 3'b000} +: 8]};
    end
    // Narrow mode only ever uses the low lane
    if (!active) begin
      d.lb_n = 1'b1;
      d.ub_n = 1'b1;
    end else if (!wide) begin
      d.lb_n = 1'b0;
      d.ub_n = 1'b1;
    end else if (d.j_size == esb_pkg::SIZE_BYTE) begin
      d.lb_n = d.j_addr[0];
      d.ub_n = !d.j_addr[0];
    end else begin
      d.lb_n = 1'b0;
      d.ub_n = 1'b0;
    end

    // Phase length seen by the checks below
    d.run = cnt_load ? 3'h0 : q.run + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.cfg <= esb_pkg::CFG_RESET;
      q.hready_o <= 1'b1;
      q.doe_n <= 1'b1;
      q.we_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.ce_n <= 1'b1;
      q.lb_n <= 1'b1;
      q.ub_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign hreadyout = q.hready_o;
  assign hrdata = q.hrdata;
  assign hresp = q.hresp;
  assign ext_addr = q.ea;
  assign ext_write_data = q.ewd;
  assign data_drive_enable_n = q.doe_n;
  assign mem_write_strobe_n = q.we_n;
  assign mem_read_enable_n = q.oe_n;
  assign mem_select_n = q.ce_n;
  assign low_lane_enable_n = q.lb_n;
  assign high_lane_enable_n = q.ub_n;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  always_okay_a: assert property (hresp == esb_pkg::HRESP_OKAY)
    else $error("error response issued");
  busy_not_ready_a: assert property (
    q.st != esb_pkg::ST_IDLE |-> !hreadyout)
    else $error("ready high while external cycles run");
  turn_len_a: assert property (
    q.st == esb_pkg::ST_TURN && cnt_last |-> q.run == ta_set)
    else $error("turnaround length wrong");
  read_len_a: assert property (
    q.st == esb_pkg::ST_READ && cnt_last |-> q.run == rd_set)
    else $error("read phase length wrong");
  write_len_a: assert property (
    q.st == esb_pkg::ST_WRITE && cnt_last |-> q.run == wr_set)
    else $error("write strobe length wrong");
  write_setup_a: assert property (
    $fell(mem_write_strobe_n) |-> $past(!data_drive_enable_n)
    && $past(!mem_select_n))
    else $error("no setup cycle before write strobe");
  write_hold_a: assert property (
    $rose(mem_write_strobe_n) |-> !data_drive_enable_n && !mem_select_n
    ##1 data_drive_enable_n || mem_write_strobe_n)
    else $error("no hold cycle after write strobe");
  no_fight_a: assert property (
    $fell(mem_read_enable_n) |-> $past(data_drive_enable_n, 1)
    && $past(data_drive_enable_n, 2))
    else $error("read started while data still driven");
  strobe_select_a: assert property (
    !mem_write_strobe_n || !mem_read_enable_n |-> !mem_select_n)
    else $error("strobe without chip select");
  narrow_lane_a: assert property (
    !wide && !mem_select_n |-> high_lane_enable_n && !low_lane_enable_n)
    else $error("high lane used in 8-bit mode");
  done_ready_a: assert property (
    q.st == esb_pkg::ST_READ && cnt_last && q.beats_left == 2'h0
    |=> hreadyout && hrdata == $past(d.j_rdata))
    else $error("read data not returned after last beat");

  read_done_c: cover property (
    q.st == esb_pkg::ST_READ ##1 q.st == esb_pkg::ST_IDLE);
  turn_seen_c: cover property (q.st == esb_pkg::ST_TURN);
  split_write_c: cover property (
    q.st == esb_pkg::ST_HOLD ##1 q.st == esb_pkg::ST_SETUP);
endmodule
`default_nettype wire

/* File: src/esb_buf2.sv */
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module esb_buf2 #(
  parameter int unsigned W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [esb_pkg::BUF_DEPTH-1:0][W-1:0] data;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } esb_buf_state_t;

  esb_buf_state_t q;
  esb_buf_state_t d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != 2'(esb_pkg::BUF_DEPTH));
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.data[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.data[q.wp] = in_data;
      d.wp = !q.wp;
    end
    if (pop) begin
      d.rp = !q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  buf_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.cnt <= 2'(esb_pkg::BUF_DEPTH))
    else $error("buffer holds more entries than it has");
endmodule
`default_nettype wire

/* File: src/esb_pkg.sv */
// Shared constants and types for the external static memory bridge
package esb_pkg;
  localparam int unsigned ADDR_BITS_DEFAULT = 16;
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned SET_W = 3;
  localparam int unsigned BUF_DEPTH = 2;
  // Register offsets (byte addresses)
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  // Configuration register fields
  localparam int unsigned CFG_RD_LSB = 0;
  localparam int unsigned CFG_WR_LSB = 3;
  localparam int unsigned CFG_TA_LSB = 6;
  localparam int unsigned CFG_WIDE_BIT = 9;
  localparam int unsigned CFG_W = 10;
  localparam logic [9:0] CFG_RESET = 10'h000;
  // Status register fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LASTWR_BIT = 1;
  localparam int unsigned ST_QUEUED_BIT = 2;
  // Bus encodings
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TURN, ST_SETUP, ST_WRITE, ST_HOLD, ST_READ
  } esb_state_t;
endpackage

/* File: src/esb_wait_cnt.sv */
// Down-counter that times the turnaround, read and write phases
`timescale 1ns/100ps
`default_nettype none
module esb_wait_cnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [2:0] load_val,
  output logic last
);
  typedef struct packed {
    logic [2:0] cnt;
  } esb_cnt_state_t;

  esb_cnt_state_t q;
  esb_cnt_state_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (q.cnt != 3'h0) begin
      d.cnt = q.cnt - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign last = (q.cnt == 3'h0);

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !load && q.cnt != 3'h0 |=> q.cnt == $past(q.cnt) - 3'h1)
    else $error("wait counter skipped a step");
endmodule
`default_nettype wire

/* File: test/esb_sram_model.sv */
// Behavioural static memory on the far side of the bridge
`timescale 1ns/100ps
`default_nettype none
module esb_sram_model (
  input wire logic pclk,
  input wire logic wide,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_write_data,
  output logic [15:0] ext_read_data,
  input wire logic data_drive_enable_n,
  input wire logic mem_write_strobe_n,
  input wire logic mem_read_enable_n,
  input wire logic mem_select_n,
  input wire logic low_lane_enable_n,
  input wire logic high_lane_enable_n
);
  logic [7:0] mem [0:255];
  logic [15:0] last;
  logic [7:0] lo_idx;
  logic [7:0] hi_idx;
  logic rd_on;
  assign lo_idx = wide ? {ext_addr[7:1], 1'b0} : ext_addr[7:0];
  assign hi_idx = {ext_addr[7:1], 1'b1};
  assign rd_on = !mem_select_n && !mem_read_enable_n;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
    last = 16'h0000;
  end
  // Shared wire: bridge drive wins, then memory, else the inverse of the last bus value
  always_comb begin
    ext_read_data = ~last;
    if (!data_drive_enable_n) ext_read_data = ext_write_data;
    else if (rd_on) begin
      if (!wide || !low_lane_enable_n) ext_read_data[7:0] = mem[lo_idx];
      if (wide && !high_lane_enable_n) ext_read_data[15:8] = mem[hi_idx];
    end
  end
  // Writes take the wire, so an undriven strobe stores garbage
  always @(posedge pclk) begin
    last <= ext_read_data;
    if (!mem_select_n && !mem_write_strobe_n) begin
      if (!wide || !low_lane_enable_n) mem[lo_idx] <= ext_read_data[7:0];
      if (wide && !high_lane_enable_n) mem[hi_idx] <= ext_read_data[15:8];
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the external static memory bridge
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hwdata, hrdata;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] ext_addr, ext_write_data, ext_read_data;
  logic dde_n, we_n, oe_n, cs_n, lb_n, ub_n;
  logic [2:0] c_rd, c_wr, c_ta;
  logic c_wide, have_dir, last_rd, p_we, p_dde, p_cs;
  logic [1:0] lanes;
  logic [7:0] sh [0:255];
  int error_cnt, n_tests, cyc, oe_run, we_run, we_beats, gap, exp_beats;
  logic [9:0] cfgs [6] = '{10'h000, 10'h200, 10'h249, 10'h05a, 10'h3ff,
                           10'h1ff};
  assign hready = hreadyout;
  esb_bridge esb_bridge_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ext_addr(ext_addr), .ext_write_data(ext_write_data),
    .ext_read_data(ext_read_data), .data_drive_enable_n(dde_n),
    .mem_write_strobe_n(we_n), .mem_read_enable_n(oe_n), .mem_select_n(cs_n),
    .low_lane_enable_n(lb_n), .high_lane_enable_n(ub_n));
  esb_sram_model esb_sram_model_i (.pclk(pclk), .wide(c_wide),
    .ext_addr(ext_addr), .ext_write_data(ext_write_data),
    .ext_read_data(ext_read_data), .data_drive_enable_n(dde_n),
    .mem_write_strobe_n(we_n), .mem_read_enable_n(oe_n), .mem_select_n(cs_n),
    .low_lane_enable_n(lb_n), .high_lane_enable_n(ub_n));
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin monitor: times each phase against the programmed settings
  always @(posedge pclk) begin
    if (!presetn) begin
      oe_run = 0;
      we_run = 0;
      gap = 0;
      have_dir = 1'b0;
    end else begin
      check(32'(!dde_n && !oe_n), 32'h0);
      if (!oe_n || !we_n) check(32'(cs_n), 32'h0);
      if (!oe_n) oe_run++;
      else if (oe_run > 0) begin
        check(32'(oe_run), 32'(exp_beats * (c_rd + 1)));
        oe_run = 0;
      end
      if (!we_n) begin
        if (p_we) check(32'({p_dde, p_cs}), 32'h0);
        if (!c_wide) check(32'(ext_write_data[15:8]), 32'h0);
        we_run++;
        lanes = {ub_n, lb_n};
      end else if (we_run > 0) begin
        check(32'(we_run), 32'(c_wr + 1));
        check(32'({dde_n, cs_n}), 32'h0);
        we_run = 0;
        we_beats++;
      end
      if (!oe_n || !dde_n) begin
        if (have_dir && last_rd != !oe_n) check(32'(gap > c_ta), 32'h1);
        gap = 0;
        have_dir = 1'b1;
        last_rd = !oe_n;
      end else gap++;
    end
    p_we = we_n;
    p_dde = dde_n;
    p_cs = cs_n;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout may end this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_cfg(input logic [9:0] v);
    logic [31:0] d;
    logic e;
    // Settings only change while the bridge is idle
    apb(1'b1, esb_pkg::CFG_OFFSET, {22'h0, v}, d, e);
    apb(1'b0, esb_pkg::CFG_OFFSET, 32'h0, d, e);
    check(d, {22'h0, v});
    {c_wide, c_ta, c_wr, c_rd} = v;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [1:0] sz,
                     input logic [31:0] wd);
    int nb;
    logic [31:0] m;
    logic [31:0] ex;
    nb = c_wide ? ((sz == esb_pkg::SIZE_WORD) ? 2 : 1) : (1 << sz);
    m = (sz == esb_pkg::SIZE_BYTE) ? 32'h0000_00ff << (8 * a[1:0]) :
        (sz == esb_pkg::SIZE_HALF) ? 32'h0000_ffff << (16 * a[1]) :
        32'hffff_ffff;
    @(posedge pclk);
    exp_beats = nb;
    we_beats = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= {1'b0, sz};
    @(posedge pclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge pclk);
    end while (hreadyout !== 1'b1);
    check(32'(hresp), 32'(esb_pkg::HRESP_OKAY));
    ex = {sh[{a[7:2], 2'd3}], sh[{a[7:2], 2'd2}], sh[{a[7:2], 2'd1}],
          sh[{a[7:2], 2'd0}]};
    if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (m[8 * b]) sh[{a[7:2], 2'(b)}] = wd[8 * b +: 8];
      end
      check(32'(we_beats), 32'(nb));
      ex = (sz == 0) ? (a[0] ? 32'h1 : 32'h2) : 32'h0;
      if (c_wide) check(32'(lanes), ex);
    end else check(hrdata & m, ex & m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic e;
    logic [31:0] v;
    logic [7:0] b;
    {psel, penable, pwrite, hsel, hwrite} = 5'h00;
    {paddr, pwdata, haddr, hwdata, htrans, hsize} = '0;
    {error_cnt, n_tests, cyc, exp_beats} = '0;
    c_wide = 1'b0;
    for (int i = 0; i < 256; i++) sh[i] = i[7:0];
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, esb_pkg::CFG_OFFSET, 32'h0, d, e);
    check(d, {22'h0, esb_pkg::CFG_RESET});
    apb(1'b0, esb_pkg::STATUS_OFFSET, 32'h0, d, e);
    check(d, 32'h0);
    apb(1'b1, 12'h008, 32'hffff_ffff, d, e);
    check(32'(e), 32'h1);
    apb(1'b0, 12'h008, 32'h0, d, e);
    check({31'h0, e} ^ d, 32'h1);
    apb(1'b1, esb_pkg::CFG_OFFSET, 32'hffff_ffff, d, e);
    apb(1'b0, esb_pkg::CFG_OFFSET, 32'h0, d, e);
    check(d, 32'h0000_03ff);
    for (int i = 0; i < 6; i++) begin
      set_cfg(cfgs[i]);
      b = 8'(16 * i);
      v = 32'h8c4e_2d71 ^ 32'(i * 32'h0101_0101);
      ahb(1'b1, b, esb_pkg::SIZE_WORD, v);
      ahb(1'b0, b, esb_pkg::SIZE_WORD, 32'h0);
      ahb(1'b1, b + 8'd1, esb_pkg::SIZE_BYTE, ~v);
      ahb(1'b1, b + 8'd6, esb_pkg::SIZE_HALF, {v[15:0], v[31:16]});
      ahb(1'b0, b + 8'd6, esb_pkg::SIZE_HALF, 32'h0);
      ahb(1'b0, b + 8'd1, esb_pkg::SIZE_BYTE, 32'h0);
      ahb(1'b0, b, esb_pkg::SIZE_WORD, 32'h0);
      ahb(1'b1, b + 8'd2, esb_pkg::SIZE_BYTE, {4{8'h5a}});
      ahb(1'b0, b, esb_pkg::SIZE_WORD, 32'h0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
